// ==== pkg/thermal_pkg.sv ====
// constants, register map and reset values of the thermal overload replica
package thermal_pkg;

  localparam int unsigned CLK_HZ             = 50_000_000;
  localparam int unsigned SAMPLE_HZ_50       = 800;
  localparam int unsigned SAMPLE_HZ_60       = 960;
  localparam int unsigned SAMPLE_DIV_50      = CLK_HZ / SAMPLE_HZ_50;
  localparam int unsigned SAMPLE_DIV_60      = CLK_HZ / SAMPLE_HZ_60;
  localparam int unsigned SAMPLES_PER_PERIOD = 16;
  localparam int unsigned SAMPLE_SHIFT       = 4;
  localparam int unsigned STEP_US_50         = 1_000_000 * SAMPLES_PER_PERIOD / SAMPLE_HZ_50;
  localparam int unsigned STEP_US_60         = 1_000_000 * SAMPLES_PER_PERIOD / SAMPLE_HZ_60;
  localparam int unsigned TAU_UNIT_US        = 1000;

  localparam int unsigned FRAC_W  = 16;
  localparam int unsigned THETA_W = 32;
  localparam int unsigned COEF_W  = 17;
  localparam int unsigned DIV_W   = 48;
  localparam logic [COEF_W-1:0] COEF_ONE = 17'h10000;

  localparam int unsigned REG_AW = 8;
  localparam logic [REG_AW-1:0] OFF_CTRL       = 8'h00;
  localparam logic [REG_AW-1:0] OFF_BASIC      = 8'h04;
  localparam logic [REG_AW-1:0] OFF_KFACTOR    = 8'h08;
  localparam logic [REG_AW-1:0] OFF_TAU_WARM   = 8'h0c;
  localparam logic [REG_AW-1:0] OFF_TAU_COOL   = 8'h10;
  localparam logic [REG_AW-1:0] OFF_THETA      = 8'h14;
  localparam logic [REG_AW-1:0] OFF_MAX_RMS    = 8'h18;
  localparam logic [REG_AW-1:0] OFF_IRQ_STATUS = 8'h1c;
  localparam logic [REG_AW-1:0] OFF_IRQ_MASK   = 8'h20;
  localparam logic [REG_AW-1:0] OFF_PICKUP     = 8'h24;

  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_60_BIT  = 1;
  localparam int unsigned IRQ_TRIP_BIT = 0;
  localparam int unsigned IRQ_STEP_BIT = 1;

  localparam logic [1:0]  CTRL_RST     = 2'h1;
  localparam logic [15:0] BASIC_RST    = 16'h0400;
  localparam logic [15:0] KFACTOR_RST  = 16'h0080;
  localparam logic [31:0] TAU_WARM_RST = 32'h000927c0;
  localparam logic [31:0] TAU_COOL_RST = 32'h00124f80;
  localparam logic [1:0]  IRQ_RST      = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : thermal_pkg

// ==== rtl/rms_isqrt.sv ====
// serial integer square root, one result bit per clock
`timescale 1ns/10ps
module rms_isqrt #(
  parameter int unsigned IN_W = 32
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              start,
  input  wire logic [IN_W-1:0]   value,
  output logic                   done,
  output logic [IN_W/2-1:0]      root
);
  localparam int unsigned OUT_W = IN_W / 2;

  logic [IN_W-1:0]  x_r;
  logic [OUT_W+1:0] rem_r;
  logic [OUT_W-1:0] root_r;
  logic [4:0]       cnt_r;
  logic             busy_r;
  logic             done_r;
  logic [OUT_W+3:0] rem_sh;
  logic [OUT_W+3:0] trial;
  logic [OUT_W+3:0] diff;
  logic             ge;

  always_comb begin
    rem_sh = {rem_r, x_r[IN_W-1 -: 2]};
    trial  = {2'b00, root_r, 2'b01};
    diff   = rem_sh - trial;
    ge     = (rem_sh >= trial);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_r    <= '0;
      rem_r  <= '0;
      root_r <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        x_r    <= value;
        rem_r  <= '0;
        root_r <= '0;
        cnt_r  <= '0;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        x_r    <= {x_r[IN_W-3:0], 2'b00};
        rem_r  <= ge ? diff[OUT_W+1:0] : rem_sh[OUT_W+1:0];
        root_r <= {root_r[OUT_W-2:0], ge};
        cnt_r  <= cnt_r + 5'h01;
        if (cnt_r == 5'(OUT_W - 1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign done = done_r;
  assign root = root_r;

endmodule : rms_isqrt

// ==== rtl/thermal_overload_replica.sv ====
// thermal replica: rms front end, exponential recursion, trip and axi4-lite registers
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module thermal_overload_replica
  import thermal_pkg::*;
#(
  parameter int unsigned DIV_50 = SAMPLE_DIV_50,
  parameter int unsigned DIV_60 = SAMPLE_DIV_60,
  parameter int unsigned SMP_W  = 16
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [REG_AW-1:0]       s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [REG_AW-1:0]       s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic signed [SMP_W-1:0] phase_a,
  input  wire logic signed [SMP_W-1:0] phase_b,
  input  wire logic signed [SMP_W-1:0] phase_c,
  output logic                         sample_strobe,
  output logic                         step_done,
  output logic                         thermal_trip,
  output logic                         irq
);
  localparam int unsigned SQ_W  = 2 * SMP_W;
  localparam int unsigned ACC_W = SQ_W + SAMPLE_SHIFT;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_COEF_W = 6'b000010,
    ST_COEF_C = 6'b000100,
    ST_SQRT   = 6'b001000,
    ST_DIV    = 6'b010000,
    ST_UPD    = 6'b100000
  } step_state_e;

  // ---------------- register bus ----------------
  logic              aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [REG_AW-1:0] aw_addr_r;
  logic [31:0]       w_data_r, rdata_r, wmask, wval, rd_val;
  logic [3:0]        w_strb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic              do_write, rd_take, wr_bad, rd_bad;
  logic              wr_ctrl, wr_basic, wr_k, wr_tw, wr_tc, wr_stat, wr_mask;
  logic [1:0]        ctrl_r, irq_stat_r, irq_mask_r;
  logic [15:0]       basic_r, k_r;
  logic [31:0]       tau_w_r, tau_c_r;

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_arready = ~rvalid_r;
  assign do_write      = aw_full_r & w_full_r & ~bvalid_r;
  assign rd_take       = s_axi_arvalid & ~rvalid_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{w_strb_r[i]}};
    end
    wval = w_data_r & wmask;
  end

  always_comb begin
    wr_ctrl  = 1'b0;
    wr_basic = 1'b0;
    wr_k     = 1'b0;
    wr_tw    = 1'b0;
    wr_tc    = 1'b0;
    wr_stat  = 1'b0;
    wr_mask  = 1'b0;
    wr_bad   = 1'b0;
    if (aw_addr_r == OFF_CTRL) begin
      wr_ctrl = do_write;
    end else if (aw_addr_r == OFF_BASIC) begin
      wr_basic = do_write;
    end else if (aw_addr_r == OFF_KFACTOR) begin
      wr_k = do_write;
    end else if (aw_addr_r == OFF_TAU_WARM) begin
      wr_tw = do_write;
    end else if (aw_addr_r == OFF_TAU_COOL) begin
      wr_tc = do_write;
    end else if (aw_addr_r == OFF_IRQ_STATUS) begin
      wr_stat = do_write;
    end else if (aw_addr_r == OFF_IRQ_MASK) begin
      wr_mask = do_write;
    end else if (aw_addr_r != OFF_THETA && aw_addr_r != OFF_MAX_RMS
                 && aw_addr_r != OFF_PICKUP) begin
      wr_bad = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_full_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[REG_AW-1:2], 2'b00};
      end else if (do_write) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_r <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ---------------- configuration registers ----------------
  logic coefw_pend_r, coefc_pend_r;
  logic coefw_start, coefc_start;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= CTRL_RST;
      basic_r    <= BASIC_RST;
      k_r        <= KFACTOR_RST;
      tau_w_r    <= TAU_WARM_RST;
      tau_c_r    <= TAU_COOL_RST;
      irq_mask_r <= IRQ_RST;
    end else begin
      if (wr_ctrl)  ctrl_r     <= (ctrl_r & ~wmask[1:0]) | wval[1:0];
      if (wr_basic) basic_r    <= (basic_r & ~wmask[15:0]) | wval[15:0];
      if (wr_k)     k_r        <= (k_r & ~wmask[15:0]) | wval[15:0];
      if (wr_tw)    tau_w_r    <= (tau_w_r & ~wmask) | wval;
      if (wr_tc)    tau_c_r    <= (tau_c_r & ~wmask) | wval;
      if (wr_mask)  irq_mask_r <= (irq_mask_r & ~wmask[1:0]) | wval[1:0];
    end
  end

  // recompute on new time constant or new mains rate; a setting wins over a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coefw_pend_r <= 1'b1;
      coefc_pend_r <= 1'b1;
    end else begin
      if (wr_tw || wr_ctrl) coefw_pend_r <= 1'b1;
      else if (coefw_start) coefw_pend_r <= 1'b0;
      if (wr_tc || wr_ctrl) coefc_pend_r <= 1'b1;
      else if (coefc_start) coefc_pend_r <= 1'b0;
    end
  end

  // ---------------- sampling and rms ----------------
  logic [16:0] smp_cnt_r, smp_lim;
  logic        strobe_r;
  logic [3:0]  smp_idx_r;
  logic        period_end;
  logic signed [SMP_W-1:0] ph [3];
  logic [SQ_W-1:0]         mean_r [3];
  logic [SQ_W-1:0]         max_mean;

  assign ph[0] = phase_a;
  assign ph[1] = phase_b;
  assign ph[2] = phase_c;
  assign smp_lim = ctrl_r[CTRL_60_BIT] ? 17'(DIV_60 - 1) : 17'(DIV_50 - 1);
  assign period_end = strobe_r && (smp_idx_r == 4'(SAMPLES_PER_PERIOD - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_cnt_r <= '0;
      strobe_r  <= 1'b0;
    end else if (!ctrl_r[CTRL_EN_BIT]) begin
      smp_cnt_r <= '0;
      strobe_r  <= 1'b0;
    end else if (smp_cnt_r >= smp_lim) begin
      smp_cnt_r <= '0;
      strobe_r  <= 1'b1;
    end else begin
      smp_cnt_r <= smp_cnt_r + 17'h00001;
      strobe_r  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_idx_r <= '0;
    end else if (strobe_r) begin
      smp_idx_r <= smp_idx_r + 4'h1;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_phase
    logic signed [SQ_W-1:0] prod;
    logic [ACC_W-1:0]       acc_r, acc_sum;
    assign prod    = ph[g] * ph[g];
    assign acc_sum = acc_r + ACC_W'(unsigned'(prod));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc_r     <= '0;
        mean_r[g] <= '0;
      end else if (period_end) begin
        acc_r     <= '0;
        mean_r[g] <= acc_sum[ACC_W-1:SAMPLE_SHIFT];
      end else if (strobe_r) begin
        acc_r <= acc_sum;
      end
    end
  end

  // root is monotonic, so the largest mean gives the largest magnitude
  always_comb begin
    max_mean = mean_r[0];
    if (mean_r[1] > max_mean) max_mean = mean_r[1];
    if (mean_r[2] > max_mean) max_mean = mean_r[2];
  end

  // ---------------- shared serial divider ----------------
  logic             div_start, dv_busy_r, dv_done_r;
  logic [DIV_W-1:0] div_num, div_den, dv_rem_r, dv_quo_r, dv_den_r;
  logic [DIV_W:0]   dv_trial, dv_diff;
  logic [5:0]       dv_cnt_r;
  logic             dv_ge;

  assign dv_trial = {dv_rem_r, dv_quo_r[DIV_W-1]};
  assign dv_diff  = dv_trial - {1'b0, dv_den_r};
  assign dv_ge    = (dv_trial >= {1'b0, dv_den_r});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dv_rem_r  <= '0;
      dv_quo_r  <= '0;
      dv_den_r  <= '0;
      dv_cnt_r  <= '0;
      dv_busy_r <= 1'b0;
      dv_done_r <= 1'b0;
    end else begin
      dv_done_r <= 1'b0;
      if (div_start) begin
        dv_rem_r  <= '0;
        dv_quo_r  <= div_num;
        dv_den_r  <= div_den;
        dv_cnt_r  <= '0;
        dv_busy_r <= 1'b1;
      end else if (dv_busy_r) begin
        dv_rem_r <= dv_ge ? dv_diff[DIV_W-1:0] : dv_trial[DIV_W-1:0];
        dv_quo_r <= {dv_quo_r[DIV_W-2:0], dv_ge};
        dv_cnt_r <= dv_cnt_r + 6'h01;
        if (dv_cnt_r == 6'(DIV_W - 1)) begin
          dv_busy_r <= 1'b0;
          dv_done_r <= 1'b1;
        end
      end
    end
  end

  // ---------------- step sequencer ----------------
  step_state_e       state_r;
  logic              step_pend_r, sq_start, sq_done, upd_done_r;
  logic [SMP_W-1:0]  sq_root, cur_i_r, prev_i_r;
  logic [31:0]       pickup_full, thresh;
  logic [23:0]       pickup;
  logic [DIV_W-1:0]  pickup_sq, step_num;
  logic [COEF_W-1:0] coef_w_r, coef_c_r, coef_sel, coef_q;
  logic [THETA_W-1:0] ss_r, theta_r, theta_nxt;
  logic signed [THETA_W:0]          diff;
  logic signed [THETA_W+COEF_W+1:0] prod_t;
  logic signed [THETA_W:0]          decay;
  logic signed [THETA_W+1:0]        sum_t;
  logic              trip_r;
  logic              trip_nxt;

  assign pickup_full = basic_r * k_r;
  assign pickup      = pickup_full[31:8];
  assign pickup_sq   = pickup * pickup;
  assign step_num    = DIV_W'(ctrl_r[CTRL_60_BIT] ? STEP_US_60 : STEP_US_50) << FRAC_W;
  assign coef_q      = (dv_quo_r >= DIV_W'(COEF_ONE)) ? '0 : COEF_ONE - dv_quo_r[COEF_W-1:0];
  assign coefw_start = (state_r == ST_IDLE) && coefw_pend_r;
  assign coefc_start = (state_r == ST_IDLE) && !coefw_pend_r && coefc_pend_r;

  rms_isqrt #(.IN_W(SQ_W)) u_isqrt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (sq_start),
    .value   (max_mean),
    .done    (sq_done),
    .root    (sq_root)
  );

  // divider launches: step_interval over tau, or current squared over pickup squared
  always_comb begin
    div_start = 1'b0;
    div_num   = '0;
    div_den   = '0;
    sq_start  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (coefw_start) begin
          div_start = 1'b1;
          div_num   = step_num;
          div_den   = DIV_W'(tau_w_r) * DIV_W'(TAU_UNIT_US);
        end else if (coefc_start) begin
          div_start = 1'b1;
          div_num   = step_num;
          div_den   = DIV_W'(tau_c_r) * DIV_W'(TAU_UNIT_US);
        end else if (step_pend_r) begin
          sq_start = 1'b1;
        end
      end
      ST_SQRT: begin
        if (sq_done) begin
          div_start = 1'b1;
          div_num   = (DIV_W'(sq_root) * DIV_W'(sq_root)) << FRAC_W;
          div_den   = pickup_sq;
        end
      end
      default: begin
        div_start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= ST_IDLE;
      coef_w_r <= '0;
      coef_c_r <= '0;
      cur_i_r  <= '0;
      ss_r     <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (coefw_start) state_r <= ST_COEF_W;
          else if (coefc_start) state_r <= ST_COEF_C;
          else if (step_pend_r) state_r <= ST_SQRT;
        end
        ST_COEF_W: begin
          if (dv_done_r) begin
            coef_w_r <= coef_q;
            state_r  <= ST_IDLE;
          end
        end
        ST_COEF_C: begin
          if (dv_done_r) begin
            coef_c_r <= coef_q;
            state_r  <= ST_IDLE;
          end
        end
        ST_SQRT: begin
          if (sq_done) begin
            cur_i_r <= sq_root;
            state_r <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (dv_done_r) begin
            ss_r    <= (|dv_quo_r[DIV_W-1:THETA_W]) ? '1 : dv_quo_r[THETA_W-1:0];
            state_r <= ST_UPD;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // a period end wins over the start of its consumer
  always_ff @(posedge aclk) begin
    if (!aresetn) step_pend_r <= 1'b0;
    else if (period_end) step_pend_r <= 1'b1;
    else if (sq_start) step_pend_r <= 1'b0;
  end

  assign coef_sel = (cur_i_r >= prev_i_r) ? coef_w_r : coef_c_r;

  // theta_n = ss + (theta_prev - ss) * (1 - step_interval / tau), the factor clamped at 0
  always_comb begin
    diff      = $signed({1'b0, theta_r}) - $signed({1'b0, ss_r});
    prod_t    = diff * $signed({1'b0, coef_sel});
    decay     = prod_t[FRAC_W +: THETA_W+1];
    sum_t     = $signed({2'b00, ss_r}) + decay;
    theta_nxt = sum_t[THETA_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      theta_r    <= '0;
      prev_i_r   <= '0;
      upd_done_r <= 1'b0;
    end else begin
      upd_done_r <= (state_r == ST_UPD);
      if (state_r == ST_UPD) begin
        theta_r  <= theta_nxt;
        prev_i_r <= cur_i_r;
      end
    end
  end

  assign thresh   = k_r * k_r;
  assign trip_nxt = (theta_r > thresh);

  always_ff @(posedge aclk) begin
    if (!aresetn) trip_r <= 1'b0;
    else trip_r <= trip_nxt;
  end

  // ---------------- interrupts and read side ----------------
  logic [1:0] irq_evt;
  assign irq_evt = {upd_done_r, trip_nxt & ~trip_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat_r <= IRQ_RST;
    else if (wr_stat) irq_stat_r <= (irq_stat_r & ~wval[1:0]) | irq_evt;
    else irq_stat_r <= irq_stat_r | irq_evt;
  end

  always_comb begin
    rd_val = '0;
    rd_bad = 1'b0;
    if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_CTRL) rd_val = {30'h0, ctrl_r};
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_BASIC) rd_val = {16'h0, basic_r};
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_KFACTOR) rd_val = {16'h0, k_r};
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_TAU_WARM) rd_val = tau_w_r;
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_TAU_COOL) rd_val = tau_c_r;
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_THETA) rd_val = theta_r;
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_MAX_RMS) rd_val = 32'(cur_i_r);
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_IRQ_STATUS) rd_val = {30'h0, irq_stat_r};
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_IRQ_MASK) rd_val = {30'h0, irq_mask_r};
    else if ({s_axi_araddr[REG_AW-1:2], 2'b00} == OFF_PICKUP) rd_val = {8'h0, pickup};
    else rd_bad = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign sample_strobe = strobe_r;
  assign step_done     = upd_done_r;
  assign thermal_trip  = trip_r;
  assign irq           = |(irq_stat_r & irq_mask_r);

endmodule : thermal_overload_replica

// ==== bench/thermal_properties.sv ====
// port checker for the thermal replica
`timescale 1ns/10ps
module thermal_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sample_strobe,
  input wire logic        step_done,
  input wire logic        thermal_trip
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_WR_HELD: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels not refused");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_STROBE_GAP: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("strobes too close");
  AST_STEP_PULSE: assert property (step_done |=> !step_done [*8])
    else $error("steps too close");
  AST_TRIP_CAUSE: assert property ($changed(thermal_trip) |-> step_done || $past(step_done) || $past(s_axi_bvalid))
    else $error("trip moved without a step");
  AST_COLD_START: assert property ($rose(aresetn) |-> (!thermal_trip && !step_done) [*8])
    else $error("not cold after reset");
endmodule : thermal_properties

bind thermal_overload_replica thermal_properties u_props (.*);

// ==== bench/phase_source.sv ====
// square-wave phase source answering the sample strobe
`timescale 1ns/10ps
module phase_source (
  input  wire logic signed [15:0] amp_a,
  input  wire logic signed [15:0] amp_b,
  input  wire logic signed [15:0] amp_c,
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               sample_strobe,
  output logic signed [15:0]      phase_a,
  output logic signed [15:0]      phase_b,
  output logic signed [15:0]      phase_c
);
  logic        [3:0]  cnt_r;
  logic signed [15:0] lvl_r [3];
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cnt_r <= 4'h0;
    else if (sample_strobe)
      cnt_r <= cnt_r + 4'h1;
  end
  // new amplitudes only at a period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn || (sample_strobe && cnt_r == 4'hf))
      lvl_r <= '{amp_a, amp_b, amp_c};
  end
  // alternating sign: rms equals amplitude
  assign phase_a = cnt_r[0] ? -lvl_r[0] : lvl_r[0];
  assign phase_b = cnt_r[0] ? -lvl_r[1] : lvl_r[1];
  assign phase_c = cnt_r[0] ? -lvl_r[2] : lvl_r[2];
endmodule : phase_source

// ==== bench/thermal_overload_replica_tb.sv ====
// self-checking bench for the thermal replica
`timescale 1ns/10ps
module thermal_overload_replica_tb import thermal_pkg::*;;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_s;
  logic               aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic               s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic               s_axi_rvalid, sample_strobe, step_done, thermal_trip, irq;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [2:0]         s_axi_awprot, s_axi_arprot;
  logic [3:0]         s_axi_wstrb;
  logic [31:0]        s_axi_wdata, s_axi_rdata, rd_v;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rsp;
  logic signed [15:0] phase_a, phase_b, phase_c, amp_a, amp_b, amp_c;
  int                 miscompares = 0, checked = 0, n;
  logic [31:0]        cool [4] = '{32'h38000, 32'h2a000, 32'h15000, 32'ha800};
  row_s               rows [18] = '{
    '{1'b0, 8'h00, 32'h1, 2'h0}, '{1'b0, 8'h04, 32'h400, 2'h0}, '{1'b0, 8'h08, 32'h80, 2'h0},
    '{1'b0, 8'h0c, 32'h927c0, 2'h0}, '{1'b0, 8'h10, 32'h124f80, 2'h0},
    '{1'b0, 8'h20, 32'h0, 2'h0}, '{1'b0, 8'h14, 32'h0, 2'h0}, '{1'b0, 8'h24, 32'h200, 2'h0},
    '{1'b1, 8'h04, 32'h64, 2'h0}, '{1'b1, 8'h08, 32'h100, 2'h0}, '{1'b1, 8'h0c, 32'h28, 2'h0},
    '{1'b1, 8'h10, 32'h50, 2'h0}, '{1'b1, 8'h20, 32'h1, 2'h0}, '{1'b0, 8'h24, 32'h64, 2'h0},
    '{1'b1, 8'h28, 32'h5, 2'h2}, '{1'b0, 8'h2c, 32'h0, 2'h2}, '{1'b1, 8'h14, 32'hffff, 2'h0},
    '{1'b0, 8'h14, 32'h0, 2'h0}};

  thermal_overload_replica #(.DIV_50(20), .DIV_60(17)) DUT (.*);
  phase_source u_src (.*);

  always #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= {w, !w};
    if (w) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    end else begin
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
    end
    do @(posedge aclk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    rsp = w ? s_axi_bresp : s_axi_rresp;
    rd_v = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask : bus

  task automatic next_step;
    do @(posedge aclk); while (step_done !== 1'b1);
  endtask : next_step

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {amp_a, amp_b, amp_c} = {16'h0032, 16'h00c8, 16'h0078};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      chk(rsp, rows[i].r);
      if (!rows[i].w) chk(rd_v, rows[i].d);
    end
    next_step();
    bus(1'b0, 8'h14, 32'h0);
    chk(rd_v, 32'h20000);
    bus(1'b0, 8'h18, 32'h0);
    chk(rd_v, 32'hc8);
    chk(thermal_trip, 1'b1);
    chk(irq, 1'b1);
    bus(1'b1, 8'h1c, 32'h1);
    chk(irq, 1'b0);
    next_step();
    bus(1'b0, 8'h14, 32'h0);
    chk(rd_v, 32'h30000);
    {amp_a, amp_b, amp_c} <= '0;
    foreach (cool[i]) begin
      next_step();
      bus(1'b0, 8'h14, 32'h0);
      chk(rd_v, cool[i]);
      chk(thermal_trip, cool[i] > 32'h10000);
    end
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 8'h00, m ? 32'h3 : 32'h1);
      do @(posedge aclk); while (sample_strobe !== 1'b1);
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (sample_strobe !== 1'b1);
      chk(n, m ? 17 : 20);
    end
    bus(1'b1, 8'h00, 32'h0);
    n = 0;
    repeat (40) @(posedge aclk) n += sample_strobe;
    chk(n, 0);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, 8'h14, 32'h0);
    chk(rd_v, 32'h0);
    chk(thermal_trip, 1'b0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    conclude();
  end
endmodule : thermal_overload_replica_tb
